// ### tb.sv
// self-checking bench of the video switch register bank
`timescale 1ns/1ps
module tb;
    logic                    mclk;
    logic                    rst;
    logic [7:0]              reg_addr, reg_wdata, reg_rdata, rv, md, ct;
    logic                    reg_wr, reg_rd, clk_valid_status, auto_select;
    logic [3:0]              source_power_sense, clk_detect_raw, pw, ck;
    logic [3:0]              port_enable, clk_term_en, data_term_en;
    logic [1:0]              active_port, power_mode, p;
    vsc_pkg::vsc_edge_t      edge_rate;
    vsc_pkg::vsc_ddc_range_t ddc_offset_range_select;
    int                      mismatches = 0;
    int                      n_checks = 0;

    vsc_regs dut (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .source_power_sense(source_power_sense), .clk_detect_raw(clk_detect_raw),
        .active_port(active_port), .port_enable(port_enable), .clk_term_en(clk_term_en),
        .data_term_en(data_term_en), .clk_valid_status(clk_valid_status),
        .edge_rate(edge_rate), .ddc_offset_range_select(ddc_offset_range_select),
        .power_mode(power_mode), .auto_select(auto_select));
    vsc_host host (.mclk(mclk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd));

    always #12.5 mclk = ~mclk;

    // priority port first, then the next powered port upward with wrap
    function automatic logic [1:0] exp_pick(logic [1:0] pr, logic [3:0] pv);
        exp_pick = pr;
        for (int i = 3; i >= 1; i--)
            if (pv[2'(pr + i)])
                exp_pick = 2'(pr + i);
        if (pv[pr])
            exp_pick = pr;
    endfunction
    function automatic vsc_pkg::vsc_ddc_range_t exp_ddc(logic [1:0] c);
        case (c)
            2'h0:    exp_ddc = vsc_pkg::VSC_DDC_R2;
            2'h1:    exp_ddc = vsc_pkg::VSC_DDC_R3;
            2'h2:    exp_ddc = vsc_pkg::VSC_DDC_UNDEF;
            default: exp_ddc = vsc_pkg::VSC_DDC_R1;
        endcase
    endfunction
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e)
        begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge mclk);
        mismatches++;
        conclude();
    end

    initial
    begin
        mclk = 1'h0;
        rst = 1'h1;
        source_power_sense = 4'h0;
        clk_detect_raw = 4'h0;
        void'($urandom(32'h4a4f));
        repeat (4) @(posedge mclk);
        rst <= 1'h0;
        @(posedge mclk);
        #1;
        chk("active_port", 8'h00, {6'h0, active_port});
        chk("port_enable", 8'h01, {4'h0, port_enable});
        chk("ddc_range", 8'h03, {6'h0, ddc_offset_range_select});
        chk("edge_rate", 8'h00, {6'h0, edge_rate});
        host.rd(8'h02, rv);
        chk("mode_reset", 8'h00, rv);
        host.rd(8'h03, rv);
        chk("ctrl_reset", 8'h08, rv);
        for (int e = 0; e < 4; e++)
        begin
            md = {2'($urandom), 1'h0, 2'(e), 1'h0, 2'(3 - e)};
            host.wr(8'h02, md);
            host.rd(8'h02, rv);
            chk("mode", md, rv);
            chk("mode_out", {4'h0, md[7:6], md[1:0]}, {4'h0, power_mode, edge_rate});
        end
        for (int i = 0; i < 24; i++)
        begin
            ct = 8'($urandom);
            ct[7] = (i % 4 == 3);
            ck = (i == 0) ? 4'h0 : 4'($urandom);
            @(posedge mclk);
            clk_detect_raw <= ck;
            host.wr(8'h03, ct);
            repeat (4) @(posedge mclk);
            #1;
            p = ct[6:5];
            chk("active_port", {6'h0, p}, {6'h0, active_port});
            chk("port_clk_en", {4'h1 << p, 4'h1 << p}, {port_enable, clk_term_en});
            chk("data_term", (ct[7] | ck[p]) ? 8'h01 << p : 8'h00, {4'h0, data_term_en});
            chk("clk_valid", {7'h0, ct[7] | ck[p]}, {7'h0, clk_valid_status});
            chk("ddc_range", {6'h0, exp_ddc(ct[4:3])}, {6'h0, ddc_offset_range_select});
            host.rd(8'h03, rv);
            chk("ctrl", ct & 8'hF8, rv);
        end
        // offset 07 is unmapped in this bank and must behave like the reserved ones
        for (int j = 4; j < 8; j++)
        begin
            host.wr(8'(j), 8'($urandom));
            host.rd(8'(j), rv);
            chk("reserved", 8'h00, rv);
        end
        host.rd(8'h02, rv);
        chk("mode_kept", md, rv);
        host.rd(8'h03, rv);
        chk("ctrl_kept", ct & 8'hF8, rv);
        for (int i = 0; i < 16; i++)
        begin
            md = {2'h0, 1'h1, 2'($urandom), 3'h0};
            pw = (i == 0) ? 4'h0 : 4'($urandom);
            @(posedge mclk);
            source_power_sense <= pw;
            host.wr(8'h02, md);
            repeat (4) @(posedge mclk);
            #1;
            chk("auto_port", {6'h0, exp_pick(md[4:3], pw)}, {6'h0, active_port});
            chk("auto_sel", 8'h01, {7'h0, auto_select});
        end
        host.wr(8'h02, 8'h00);
        repeat (4) @(posedge mclk);
        #1;
        chk("manual_back", {6'h0, ct[6:5]}, {6'h0, active_port});
        conclude();
    end
endmodule

// ### vsc_host.sv
// host model that drives the byte register port of the bank
`timescale 1ns/1ps
module vsc_host (
    input  wire logic       mclk,
    input  wire logic [7:0] reg_rdata,
    output logic      [7:0] reg_addr,
    output logic            reg_wr,
    output logic      [7:0] reg_wdata,
    output logic            reg_rd
);
    initial
    begin
        reg_addr  = 8'h00;
        reg_wr    = 1'h0;
        reg_wdata = 8'h00;
        reg_rd    = 1'h0;
    end
    // released lines show the inverse so stale values cannot pass
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] dd;
        dd = (a == 8'h02) ? (d & 8'hFB) : d;
        @(posedge mclk);
        reg_addr  <= a;
        reg_wdata <= dd;
        reg_wr    <= 1'h1;
        @(posedge mclk);
        reg_wr    <= 1'h0;
        reg_addr  <= ~a;
        reg_wdata <= ~dd;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd   <= 1'h1;
        @(posedge mclk);
        reg_rd   <= 1'h0;
        reg_addr <= ~a;
        #1;
        d = reg_rdata;
    endtask
endmodule

// ### vsc_map.svh
// offsets, field positions and reset values of the video switch register bank
`ifndef VSC_MAP_SVH
`define VSC_MAP_SVH
`define VSC_OFS_MODE        8'h02
`define VSC_OFS_CTRL        8'h03
`define VSC_OFS_RSVD_A      8'h04
`define VSC_OFS_RSVD_B      8'h05
`define VSC_OFS_RSVD_C      8'h06
`define VSC_MODE_RST        8'h00
`define VSC_CTRL_RST        8'h08
`define VSC_MODE_WMASK      8'hFB
`define VSC_CTRL_WMASK      8'hF8
`define VSC_RSVD_RDVAL      8'h00
`define VSC_UNMAPPED_RDVAL  8'h00
`define VSC_MODE_PWR_HI     7
`define VSC_MODE_PWR_LO     6
`define VSC_MODE_AUTO       5
`define VSC_MODE_PRIO_HI    4
`define VSC_MODE_PRIO_LO    3
`define VSC_MODE_RSVD       2
`define VSC_MODE_EDGE_HI    1
`define VSC_MODE_EDGE_LO    0
`define VSC_CTRL_CLKDET_DIS 7
`define VSC_CTRL_PORT_HI    6
`define VSC_CTRL_PORT_LO    5
`define VSC_CTRL_DDC_HI     4
`define VSC_CTRL_DDC_LO     3
`define VSC_DDC_CODE_R2     2'h0
`define VSC_DDC_CODE_R3     2'h1
`define VSC_DDC_CODE_UNDEF  2'h2
`define VSC_DDC_CODE_R1     2'h3
`define VSC_SYNC_RST        1'h0
`endif

// ### vsc_pkg.sv
// shared types of the video switch register bank
package vsc_pkg;
    typedef logic [1:0] vsc_port_t;
    typedef logic [3:0] vsc_pmask_t;
    typedef enum logic [1:0] {
        VSC_EDGE_FAST = 2'h0,
        VSC_EDGE_P50  = 2'h1,
        VSC_EDGE_P100 = 2'h2,
        VSC_EDGE_P120 = 2'h3
    } vsc_edge_t;
    typedef enum logic [1:0] {
        VSC_DDC_UNDEF = 2'h0,
        VSC_DDC_R1    = 2'h1,
        VSC_DDC_R2    = 2'h2,
        VSC_DDC_R3    = 2'h3
    } vsc_ddc_range_t;
endpackage

// ### vsc_port_pick.sv
// active port choice: manual field, or priority port first then rotating scan
`timescale 1ns/1ps
module vsc_port_pick (
    vsc_sel_if.sel sel
);
    vsc_pkg::vsc_port_t cand;
    vsc_pkg::vsc_port_t auto_pick;
    logic               found;

    // unpowered ports everywhere: stay on the priority port
    always_comb
    begin
        auto_pick = sel.prio;
        found     = 1'h0;
        cand      = sel.prio;
        for (int i = 0; i < 4; i++)
        begin
            cand = 2'(sel.prio + 2'(i));
            if (!found && sel.power[cand])
            begin
                auto_pick = cand;
                found     = 1'h1;
            end
        end
    end

    assign sel.pick = sel.auto_en ? auto_pick : sel.manual;
endmodule

// ### vsc_regs.sv
// register bank and port steering of the four-port video input switch
`timescale 1ns/1ps
`include "vsc_map.svh"

module vsc_regs (
    input  wire logic                     mclk,
    input  wire logic                     rst,
    input  wire logic [7:0]               reg_addr,
    input  wire logic                     reg_wr,
    input  wire logic [7:0]               reg_wdata,
    input  wire logic                     reg_rd,
    output logic      [7:0]               reg_rdata,
    input  wire logic [3:0]               source_power_sense,
    input  wire logic [3:0]               clk_detect_raw,
    output logic      [1:0]               active_port,
    output logic      [3:0]               port_enable,
    output logic      [3:0]               clk_term_en,
    output logic      [3:0]               data_term_en,
    output logic                          clk_valid_status,
    output vsc_pkg::vsc_edge_t            edge_rate,
    output vsc_pkg::vsc_ddc_range_t       ddc_offset_range_select,
    output logic      [1:0]               power_mode,
    output logic                          auto_select
);
    logic [7:0]              mode_r;
    logic [7:0]              mode_nxt;
    logic [7:0]              ctrl_r;
    logic [7:0]              ctrl_nxt;
    logic [7:0]              rdata_r;
    logic [7:0]              rdata_nxt;
    vsc_pkg::vsc_port_t      act_r;
    logic [3:0]              data_term_r;
    logic                    clk_stat_r;
    vsc_pkg::vsc_ddc_range_t ddc_r;
    vsc_pkg::vsc_ddc_range_t ddc_nxt;
    logic [3:0]              power_s;
    logic [3:0]              clkdet_s;
    logic                    hit_mode;
    logic                    hit_ctrl;
    logic                    hit_rsvd;
    logic                    clkdet_dis;
    logic                    sel_clk_ok;
    logic [3:0]              act_onehot;
    logic [3:0]              data_term_nxt;
    logic [1:0]              ddc_code;

    vsc_sel_if sel_bus ();

    vsc_sync #(.W(4)) u_sync_pwr (
        .mclk (mclk),
        .rst  (rst),
        .din  (source_power_sense),
        .dout (power_s)
    );

    vsc_sync #(.W(4)) u_sync_clk (
        .mclk (mclk),
        .rst  (rst),
        .din  (clk_detect_raw),
        .dout (clkdet_s)
    );

    vsc_port_pick u_pick (
        .sel (sel_bus.sel)
    );

    // address decode
    assign hit_mode = (reg_addr == `VSC_OFS_MODE);
    assign hit_ctrl = (reg_addr == `VSC_OFS_CTRL);
    assign hit_rsvd = (reg_addr == `VSC_OFS_RSVD_A) || (reg_addr == `VSC_OFS_RSVD_B)
                   || (reg_addr == `VSC_OFS_RSVD_C);

    // reserved mode bit forced low so a stray host write cannot reach the core
    assign mode_nxt = (reg_wr && hit_mode) ? (reg_wdata & `VSC_MODE_WMASK) : mode_r;
    assign ctrl_nxt = (reg_wr && hit_ctrl) ? (reg_wdata & `VSC_CTRL_WMASK) : ctrl_r;
    // reserved offsets have no write path at all

    assign rdata_nxt = !reg_rd  ? rdata_r
                     : hit_mode ? mode_r
                     : hit_ctrl ? ctrl_r
                     : hit_rsvd ? `VSC_RSVD_RDVAL
                     :            `VSC_UNMAPPED_RDVAL;

    // selector request
    assign sel_bus.auto_en = mode_r[`VSC_MODE_AUTO];
    assign sel_bus.prio    = mode_r[`VSC_MODE_PRIO_HI:`VSC_MODE_PRIO_LO];
    assign sel_bus.manual  = ctrl_r[`VSC_CTRL_PORT_HI:`VSC_CTRL_PORT_LO];
    assign sel_bus.power   = power_s;

    assign clkdet_dis = ctrl_r[`VSC_CTRL_CLKDET_DIS];
    assign sel_clk_ok = clkdet_s[act_r];
    assign act_onehot = 4'h1 << act_r;
    // data lines gated by the seen clock unless detection is switched off
    assign data_term_nxt = (clkdet_dis || sel_clk_ok) ? act_onehot : 4'h0;

    assign ddc_code = ctrl_r[`VSC_CTRL_DDC_HI:`VSC_CTRL_DDC_LO];
    always_comb
    begin
        unique case (ddc_code)
            `VSC_DDC_CODE_R2: ddc_nxt = vsc_pkg::VSC_DDC_R2;
            `VSC_DDC_CODE_R3: ddc_nxt = vsc_pkg::VSC_DDC_R3;
            `VSC_DDC_CODE_R1: ddc_nxt = vsc_pkg::VSC_DDC_R1;
            `VSC_DDC_CODE_UNDEF: ddc_nxt = vsc_pkg::VSC_DDC_UNDEF;
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            mode_r <= `VSC_MODE_RST;
            ctrl_r <= `VSC_CTRL_RST;
            rdata_r <= `VSC_UNMAPPED_RDVAL;
        end
        else
        begin
            mode_r <= mode_nxt;
            ctrl_r <= ctrl_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // steering outputs lag the register contents by one cycle, two after the write; data_term_en and clk_valid_status lag active_port by one more
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            act_r <= 2'h0;
            data_term_r <= 4'h0;
            clk_stat_r <= 1'h0;
            ddc_r <= vsc_pkg::VSC_DDC_R3;
        end
        else
        begin
            act_r <= sel_bus.pick;
            data_term_r <= data_term_nxt;
            clk_stat_r <= clkdet_dis || sel_clk_ok;
            ddc_r <= ddc_nxt;
        end
    end

    assign reg_rdata               = rdata_r;
    assign active_port             = act_r;
    assign port_enable             = act_onehot;
    assign clk_term_en             = act_onehot;
    assign data_term_en            = data_term_r;
    assign clk_valid_status        = clk_stat_r;
    assign edge_rate = vsc_pkg::vsc_edge_t'(mode_r[`VSC_MODE_EDGE_HI:`VSC_MODE_EDGE_LO]);
    assign ddc_offset_range_select = ddc_r;
    assign power_mode              = mode_r[`VSC_MODE_PWR_HI:`VSC_MODE_PWR_LO];
    assign auto_select             = mode_r[`VSC_MODE_AUTO];

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    sequence wr_mode_s;
        reg_wr && hit_mode;
    endsequence

    sequence wr_ctrl_s;
        reg_wr && hit_ctrl;
    endsequence

    sequence manual_hold_s;
        !mode_r[`VSC_MODE_AUTO] && !reg_wr;
    endsequence

    prio_pick_a: assert property (
        (mode_r[`VSC_MODE_AUTO] && power_s[sel_bus.prio]) ##1 !reg_wr
        |-> active_port == $past(sel_bus.prio))
        else $error("priority port not chosen while powered");

    rsvd_bit_a: assert property (wr_mode_s |=> mode_r[`VSC_MODE_RSVD] == 1'h0)
        else $error("reserved mode bit took a one");

    edge_rate_a: assert property (
        wr_mode_s |=> edge_rate == vsc_pkg::vsc_edge_t'($past(reg_wdata[1:0])))
        else $error("edge rate does not follow mode write");

    term_gate_a: assert property (
        (!$past(clkdet_dis) && !$past(sel_clk_ok)) |-> data_term_en == 4'h0)
        else $error("data terminations on without a valid clock");

    term_force_a: assert property (
        clkdet_dis |=> data_term_en == (4'h1 << $past(act_r)))
        else $error("terminations off with clock detect disabled");

    manual_sel_a: assert property (
        wr_ctrl_s ##1 manual_hold_s |=> port_enable == (4'h1 << $past(reg_wdata[6:5], 2)))
        else $error("manual port not selected two cycles after write");

    ddc_range_a: assert property (
        wr_ctrl_s ##1 !reg_wr
        |=> ddc_offset_range_select == (
            $past(reg_wdata[4:3], 2) == 2'h0 ? vsc_pkg::VSC_DDC_R2
            : $past(reg_wdata[4:3], 2) == 2'h1 ? vsc_pkg::VSC_DDC_R3
            : $past(reg_wdata[4:3], 2) == 2'h3 ? vsc_pkg::VSC_DDC_R1
            : vsc_pkg::VSC_DDC_UNDEF))
        else $error("offset range not decoded from the control write");

    ctrl_read_a: assert property (
        (reg_rd && hit_ctrl) |=> reg_rdata == {ctrl_r[7:3], 3'h0})
        else $error("control register read back wrong");

    rsvd_read_a: assert property ((reg_rd && hit_rsvd) |=> reg_rdata == 8'h00)
        else $error("reserved register read not defined");

    auto_scan_a: assert property (
        (mode_r[`VSC_MODE_AUTO] && power_s == 4'h0 && !reg_wr)
        |=> active_port == $past(sel_bus.prio))
        else $error("no power sensed yet priority port not kept");

    status_one_a: assert property (clkdet_dis [*2] |-> clk_valid_status)
        else $error("valid clock status not one with detection off");

    rsvd_write_a: assert property (
        (reg_wr && hit_rsvd) |=> $stable(mode_r) && $stable(ctrl_r))
        else $error("reserved register write changed state");

    sequence no_mode_wr_s;
        !(reg_wr && hit_mode);
    endsequence

    sequence no_ctrl_wr_s;
        !(reg_wr && hit_ctrl);
    endsequence

    // a powered neighbour wins only when the priority port itself is dark
    sequence prio_dark_s;
        sel_bus.auto_en && !power_s[sel_bus.prio];
    endsequence

    mode_write_a: assert property (
        wr_mode_s |=> sel_bus.prio == $past(reg_wdata[4:3]))
        else $error("priority field does not follow mode write");

    mode_keep_a: assert property (no_mode_wr_s |=> $stable(mode_r))
        else $error("mode register changed without a write");

    edge_keep_a: assert property (no_mode_wr_s |=> $stable(edge_rate))
        else $error("edge rate changed without a mode write");

    term_on_a: assert property (
        (!clkdet_dis && sel_clk_ok) |=> data_term_en == (4'h1 << $past(act_r)))
        else $error("data terminations off although a clock is seen");

    term_single_a: assert property ($onehot0(data_term_en))
        else $error("data terminations on at more than one port");

    port_onehot_a: assert property (
        $onehot(port_enable) && clk_term_en == port_enable)
        else $error("port enables not one-hot");

    manual_follow_a: assert property (
        manual_hold_s |=> active_port == $past(sel_bus.manual))
        else $error("manual port field not followed");

    ddc_keep_a: assert property (
        no_ctrl_wr_s [*2] |=> $stable(ddc_offset_range_select))
        else $error("offset range moved without a control write");

    ctrl_write_a: assert property (
        wr_ctrl_s |=> ctrl_r == {$past(reg_wdata[7:3]), 3'h0})
        else $error("control register write not stored");

    ctrl_keep_a: assert property (no_ctrl_wr_s |=> $stable(ctrl_r))
        else $error("control register changed without a write");

    read_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data moved without a read");

    mode_read_a: assert property (
        (reg_rd && hit_mode) |=> reg_rdata == $past(mode_r))
        else $error("mode register read back wrong");

    unmapped_read_a: assert property (
        (reg_rd && !hit_mode && !hit_ctrl) |=> reg_rdata == 8'h00)
        else $error("read outside the two live registers not zero");

    auto_next_a: assert property (
        prio_dark_s ##0 power_s[2'(sel_bus.prio + 2'h1)]
        |=> active_port == 2'($past(sel_bus.prio) + 2'h1))
        else $error("next powered port not chosen after a dark priority port");

    auto_flag_a: assert property (
        wr_mode_s |=> auto_select == $past(reg_wdata[5]))
        else $error("automatic select flag does not follow mode write");

    status_zero_a: assert property (
        (!clkdet_dis && !sel_clk_ok) |=> !clk_valid_status)
        else $error("valid clock status set without a clock");
endmodule

// ### vsc_sel_if.sv
// port selection request and answer between register bank and selector
`timescale 1ns/1ps
interface vsc_sel_if;
    logic               auto_en;
    vsc_pkg::vsc_port_t prio;
    vsc_pkg::vsc_port_t manual;
    vsc_pkg::vsc_pmask_t power;
    vsc_pkg::vsc_port_t pick;
    modport ctl (output auto_en, output prio, output manual, output power, input pick);
    modport sel (input auto_en, input prio, input manual, input power, output pick);
endinterface

// ### vsc_sync.sv
// two flip-flop synchroniser for pin inputs, one stage pair per bit
`timescale 1ns/1ps
`include "vsc_map.svh"
module vsc_sync #(
    parameter int W = 4
) (
    input  wire logic         mclk,
    input  wire logic         rst,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    genvar b;
    generate
        for (b = 0; b < W; b++)
        begin : g_bit
            logic meta_r;
            logic safe_r;
            always_ff @(posedge mclk)
            begin
                if (rst)
                begin
                    meta_r <= `VSC_SYNC_RST;
                    safe_r <= `VSC_SYNC_RST;
                end
                else
                begin
                    meta_r <= din[b];
                    safe_r <= meta_r;
                end
            end
            assign dout[b] = safe_r;
        end
    endgenerate
endmodule
